// ### rtl/sgpc_consts.svh
// Purpose: constants for the switchgear position control block
// Assumes: 32-bit AXI4-Lite register slave, byte addresses
// Notes: counts are in aclk cycles (5 ns each)
`ifndef SGPC_CONSTS_SVH
`define SGPC_CONSTS_SVH
// ****************************************
// register offsets
// ****************************************
`define SGPC_OFS_CFG 8'h00
`define SGPC_OFS_CMD 8'h04
`define SGPC_OFS_STAT 8'h08
`define SGPC_OFS_TMASK 8'h0C
`define SGPC_OFS_HOLD 8'h10
`define SGPC_OFS_MVON 8'h14
`define SGPC_OFS_MVOFF 8'h18
`define SGPC_OFS_SYNC 8'h1C
`define SGPC_OFS_RELAY 8'h20
// ****************************************
// fields and codes
// ****************************************
`define SGPC_POS_INDET 2'h0
`define SGPC_POS_OPEN 2'h1
`define SGPC_POS_CLOSED 2'h2
`define SGPC_POS_DISTURB 2'h3
`define SGPC_CMD_CLOSE 0
`define SGPC_CMD_OPEN 1
`define SGPC_CMD_ACK 2
`define SGPC_RELAY_OP_LSB 8
`define SGPC_RESP_OKAY 2'h0
`define SGPC_RESP_SLVERR 2'h2
// ****************************************
// reset values
// ****************************************
`define SGPC_RST_CFG 8'h81
`define SGPC_RST_TMASK 8'hFF
`define SGPC_RST_HOLD 32'h0000_0014
`define SGPC_RST_MVON 32'h0000_1000
`define SGPC_RST_MVOFF 32'h0000_1000
`define SGPC_RST_SYNC 32'h0000_1000
`define SGPC_RST_REL_CL 7'h01
`define SGPC_RST_REL_OP 7'h06
`endif

// ### rtl/sgpc_pkg.sv
// Purpose: types for the switchgear position control block
// Assumes: nothing beyond the constants header
// Notes: all state of the top lives in sgpc_st_s
`default_nettype none
package sgpc_pkg;
	typedef enum logic [3:0] {
		SGPC_IDLE = 4'h1,
		SGPC_SYNC = 4'h2,
		SGPC_CLOSING = 4'h4,
		SGPC_OPENING = 4'h8
	} sgpc_fsm_e;
	typedef struct packed {
		logic switch_one;
		logic gen2sys;
		logic sync_en;
		logic ack_ext;
		logic latched;
		logic earthing;
		logic controlled;
		logic break_cap;
	} sgpc_cfg_s;
	typedef struct packed {
		logic sync_abort;
		logic open_fault;
		logic close_fault;
		logic open_rej;
		logic close_rej;
	} sgpc_sticky_s;
	typedef struct packed {
		logic aw_rdy, w_rdy, aw_hold, w_hold;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy, rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		sgpc_cfg_s cfg;
		logic [7:0] tmask;
		logic [31:0] hold, mvon, mvoff, sync;
		logic [6:0] rel_cl, rel_op;
		logic [1:0] pos;
		logic ready, removed, earthed;
		sgpc_fsm_e fsm;
		logic [31:0] cnt, hold_cnt;
		logic trip_act, close_rel, open_rel, cfg_rej;
		sgpc_sticky_s sticky;
		logic ext_cl_q, ext_op_q;
	} sgpc_st_s;
endpackage : sgpc_pkg
`default_nettype wire

// ### rtl/sgpc_top.sv
// Purpose: position decode, move supervision, interlocked commands, trip manager
// Assumes: all inputs synchronous to aclk; registers over AXI4-Lite
// Notes: one always_comb builds nxt_st, one always_ff registers it
// How it works
// - closed-position contact true means the switch is closed.
// - open-position contact true means the switch is open.
// - on an earthing part the first contact means earthed, flagged as such.
// - position code: 0 indeterminate, 1 open, 2 closed, 3 disturbed.
// - ready input is reported and offered to other functions.
// - removed input marks a withdrawable breaker as removed.
// - separate move timers supervise closing and opening after a command.
// - any of three close blocks true rejects a close command.
// - any of three open blocks true rejects an open command.
// - manual commands are taken only on a controlled switch.
// - break capable but uncontrolled: trips only, manual refused.
// - neither property: position monitoring only, no commands.
// - trip manager works only when break capability is set.
// - switch one without break capability is a rejected configuration.
// - any assigned trip source true issues the open command.
// - trip open stays asserted for at least the minimum hold time.
// - latched option keeps trip open until an acknowledgment.
// - acknowledgment source is selectable, software or external input.
// - external close and open requests act on a controlled switch.
// - each relay ORs up to three assigned command sources; a trip forces the close relay off.
// - synchronous close aborts after the wait limit, generator-to-system only.
`include "sgpc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sgpc_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// auxiliary contacts
	input wire logic aux_closed,
	input wire logic aux_open,
	input wire logic ready_in,
	input wire logic removed_in,
	// interlocks and requests
	input wire logic [2:0] close_block_input,
	input wire logic [2:0] open_block_input,
	input wire logic [7:0] trip_source_input,
	input wire logic trip_latch_clear,
	input wire logic external_close_request,
	input wire logic external_open_request,
	input wire logic sync_ok,
	// status and relays
	output logic [1:0] position,
	output logic breaker_ready,
	output logic breaker_removed,
	output logic earthed,
	output logic close_relay,
	output logic open_relay
);
	sgpc_pkg::sgpc_st_s st_ff, nxt_st;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'h0) && (a <= `SGPC_OFS_RELAY);
	endfunction : is_mapped

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++)
		begin
			merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
		end
	endfunction : merge

	logic do_wr, cfg_ok, trip_src, man_ok, cl_req, op_req, ack, cl_blk, op_blk;
	logic [1:0] pos_dec;
	logic [31:0] wv, stat, cfg_w;
	logic [6:0] srcs;
	sgpc_pkg::sgpc_sticky_s sset, sclr;

	always_comb
	begin
		nxt_st = st_ff;
		do_wr = st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid;
		wv = merge(32'h0, st_ff.w_data, st_ff.w_strb);
		cfg_w = merge({24'h0, st_ff.cfg}, st_ff.w_data, st_ff.w_strb);
		// ****************************************
		// position decode
		// ****************************************
		case ({aux_closed, aux_open})
			2'b10: pos_dec = `SGPC_POS_CLOSED;
			2'b01: pos_dec = `SGPC_POS_OPEN;
			2'b11: pos_dec = `SGPC_POS_DISTURB;
			default: pos_dec = `SGPC_POS_INDET;
		endcase
		nxt_st.pos = pos_dec;
		nxt_st.earthed = st_ff.cfg.earthing && aux_closed;
		nxt_st.ready = ready_in;
		nxt_st.removed = removed_in;
		// ****************************************
		// capability and requests
		// ****************************************
		cfg_ok = !(st_ff.cfg.switch_one && !st_ff.cfg.break_cap);
		nxt_st.cfg_rej = !cfg_ok;
		man_ok = st_ff.cfg.controlled && cfg_ok;
		trip_src = st_ff.cfg.break_cap && cfg_ok
			&& (|(trip_source_input & st_ff.tmask));
		cl_req = man_ok && ((external_close_request && !st_ff.ext_cl_q)
			|| (do_wr && st_ff.aw_addr == `SGPC_OFS_CMD && wv[`SGPC_CMD_CLOSE]));
		op_req = man_ok && ((external_open_request && !st_ff.ext_op_q)
			|| (do_wr && st_ff.aw_addr == `SGPC_OFS_CMD && wv[`SGPC_CMD_OPEN]));
		nxt_st.ext_cl_q = external_close_request;
		nxt_st.ext_op_q = external_open_request;
		cl_blk = |close_block_input;
		op_blk = |open_block_input;
		ack = st_ff.cfg.ack_ext ? trip_latch_clear
			: (do_wr && st_ff.aw_addr == `SGPC_OFS_CMD && wv[`SGPC_CMD_ACK]);
		sset = '0;
		// ****************************************
		// trip manager
		// ****************************************
		if (trip_src)
		begin
			nxt_st.trip_act = 1'b1;
			nxt_st.hold_cnt = st_ff.hold;
		end
		else if (st_ff.hold_cnt != 32'h0)
			nxt_st.hold_cnt = st_ff.hold_cnt - 32'h1;
		else if (!st_ff.cfg.latched || ack)
			nxt_st.trip_act = 1'b0;
		// ****************************************
		// switching sequence
		// ****************************************
		case (st_ff.fsm)
			sgpc_pkg::SGPC_IDLE:
			begin
				if (op_req && op_blk)
					sset.open_rej = 1'b1;
				else if (op_req && !st_ff.trip_act)
				begin
					nxt_st.fsm = sgpc_pkg::SGPC_OPENING;
					nxt_st.cnt = st_ff.mvoff;
				end
				else if (cl_req && (cl_blk || st_ff.trip_act))
					sset.close_rej = 1'b1;
				else if (cl_req && st_ff.cfg.sync_en && st_ff.cfg.break_cap)
				begin
					nxt_st.fsm = sgpc_pkg::SGPC_SYNC;
					nxt_st.cnt = st_ff.sync;
				end
				else if (cl_req)
				begin
					nxt_st.fsm = sgpc_pkg::SGPC_CLOSING;
					nxt_st.cnt = st_ff.mvon;
				end
			end
			sgpc_pkg::SGPC_SYNC:
			begin
				if (st_ff.trip_act || !man_ok || cl_blk)
					nxt_st.fsm = sgpc_pkg::SGPC_IDLE;
				else if (sync_ok)
				begin
					nxt_st.fsm = sgpc_pkg::SGPC_CLOSING;
					nxt_st.cnt = st_ff.mvon;
				end
				else if (st_ff.cfg.gen2sys && st_ff.cnt == 32'h0)
				begin
					sset.sync_abort = 1'b1;
					nxt_st.fsm = sgpc_pkg::SGPC_IDLE;
				end
				else if (st_ff.cfg.gen2sys)
					nxt_st.cnt = st_ff.cnt - 32'h1;
			end
			sgpc_pkg::SGPC_CLOSING:
			begin
				// a trip always beats a running close
				if (st_ff.trip_act || st_ff.pos == `SGPC_POS_CLOSED || !man_ok)
					nxt_st.fsm = sgpc_pkg::SGPC_IDLE;
				else if (st_ff.cnt == 32'h0)
				begin
					sset.close_fault = 1'b1;
					nxt_st.fsm = sgpc_pkg::SGPC_IDLE;
				end
				else
					nxt_st.cnt = st_ff.cnt - 32'h1;
			end
			sgpc_pkg::SGPC_OPENING:
			begin
				if (st_ff.pos == `SGPC_POS_OPEN || !man_ok)
					nxt_st.fsm = sgpc_pkg::SGPC_IDLE;
				else if (st_ff.cnt == 32'h0)
				begin
					sset.open_fault = 1'b1;
					nxt_st.fsm = sgpc_pkg::SGPC_IDLE;
				end
				else
					nxt_st.cnt = st_ff.cnt - 32'h1;
			end
			default: nxt_st.fsm = sgpc_pkg::SGPC_IDLE;
		endcase
		// ****************************************
		// relay routing
		// ****************************************
		srcs = {4'h0, st_ff.trip_act, st_ff.fsm == sgpc_pkg::SGPC_OPENING,
			st_ff.fsm == sgpc_pkg::SGPC_CLOSING};
		nxt_st.close_rel = |(srcs & st_ff.rel_cl) && !st_ff.trip_act;
		nxt_st.open_rel = |(srcs & st_ff.rel_op);
		// ****************************************
		// register bus
		// ****************************************
		stat = {14'h0, st_ff.fsm, st_ff.sticky, st_ff.cfg_rej, st_ff.open_rel,
			st_ff.close_rel, st_ff.trip_act, st_ff.earthed, st_ff.removed,
			st_ff.ready, st_ff.pos};
		if (s_axi_awvalid && st_ff.aw_rdy)
		begin
			nxt_st.aw_hold = 1'b1;
			nxt_st.aw_rdy = 1'b0;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_ff.w_rdy)
		begin
			nxt_st.w_hold = 1'b1;
			nxt_st.w_rdy = 1'b0;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end
		sclr = '0;
		if (do_wr)
		begin
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = is_mapped(st_ff.aw_addr) ? `SGPC_RESP_OKAY : `SGPC_RESP_SLVERR;
			case (st_ff.aw_addr)
				`SGPC_OFS_CFG: nxt_st.cfg = cfg_w[7:0];
				`SGPC_OFS_STAT: sclr = wv[13:9];
				`SGPC_OFS_TMASK: nxt_st.tmask = wv[7:0];
				`SGPC_OFS_HOLD: nxt_st.hold = merge(st_ff.hold, st_ff.w_data, st_ff.w_strb);
				`SGPC_OFS_MVON: nxt_st.mvon = merge(st_ff.mvon, st_ff.w_data, st_ff.w_strb);
				`SGPC_OFS_MVOFF: nxt_st.mvoff = merge(st_ff.mvoff, st_ff.w_data, st_ff.w_strb);
				`SGPC_OFS_SYNC: nxt_st.sync = merge(st_ff.sync, st_ff.w_data, st_ff.w_strb);
				`SGPC_OFS_RELAY:
				begin
					nxt_st.rel_cl = wv[6:0];
					nxt_st.rel_op = wv[`SGPC_RELAY_OP_LSB +: 7];
				end
				default: ;
			endcase
		end
		if (st_ff.bvalid && s_axi_bready)
		begin
			nxt_st.bvalid = 1'b0;
			nxt_st.aw_hold = 1'b0;
			nxt_st.w_hold = 1'b0;
			nxt_st.aw_rdy = 1'b1;
			nxt_st.w_rdy = 1'b1;
		end
		// an event in the clearing cycle survives
		nxt_st.sticky = (st_ff.sticky & ~sclr) | sset;
		if (s_axi_arvalid && st_ff.ar_rdy)
		begin
			nxt_st.ar_rdy = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = is_mapped(s_axi_araddr) ? `SGPC_RESP_OKAY : `SGPC_RESP_SLVERR;
			case (s_axi_araddr)
				`SGPC_OFS_CFG: nxt_st.rdata = {24'h0, st_ff.cfg};
				`SGPC_OFS_STAT: nxt_st.rdata = stat;
				`SGPC_OFS_TMASK: nxt_st.rdata = {24'h0, st_ff.tmask};
				`SGPC_OFS_HOLD: nxt_st.rdata = st_ff.hold;
				`SGPC_OFS_MVON: nxt_st.rdata = st_ff.mvon;
				`SGPC_OFS_MVOFF: nxt_st.rdata = st_ff.mvoff;
				`SGPC_OFS_SYNC: nxt_st.rdata = st_ff.sync;
				`SGPC_OFS_RELAY: nxt_st.rdata = {17'h0, st_ff.rel_op, 1'b0, st_ff.rel_cl};
				default: nxt_st.rdata = 32'h0;
			endcase
		end
		else if (st_ff.rvalid && s_axi_rready)
		begin
			nxt_st.rvalid = 1'b0;
			nxt_st.ar_rdy = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_ff <= '0;
			st_ff.aw_rdy <= 1'b1;
			st_ff.w_rdy <= 1'b1;
			st_ff.ar_rdy <= 1'b1;
			st_ff.cfg <= `SGPC_RST_CFG;
			st_ff.tmask <= `SGPC_RST_TMASK;
			st_ff.hold <= `SGPC_RST_HOLD;
			st_ff.mvon <= `SGPC_RST_MVON;
			st_ff.mvoff <= `SGPC_RST_MVOFF;
			st_ff.sync <= `SGPC_RST_SYNC;
			st_ff.rel_cl <= `SGPC_RST_REL_CL;
			st_ff.rel_op <= `SGPC_RST_REL_OP;
			st_ff.fsm <= sgpc_pkg::SGPC_IDLE;
		end
		else
			st_ff <= nxt_st;
	end

	assign s_axi_awready = st_ff.aw_rdy;
	assign s_axi_wready = st_ff.w_rdy;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = st_ff.ar_rdy;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rresp = st_ff.rresp;
	assign s_axi_rdata = st_ff.rdata;
	assign position = st_ff.pos;
	assign breaker_ready = st_ff.ready;
	assign breaker_removed = st_ff.removed;
	assign earthed = st_ff.earthed;
	assign close_relay = st_ff.close_rel;
	assign open_relay = st_ff.open_rel;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_pos_closed; aux_closed && !aux_open |=> position == `SGPC_POS_CLOSED; endproperty
	a_pos_closed: assert property (p_pos_closed) else $error("closed not decoded");
	property p_pos_both; aux_closed && aux_open |=> position == `SGPC_POS_DISTURB; endproperty
	a_pos_both: assert property (p_pos_both) else $error("disturbed not decoded");
	property p_ready; ready_in ##1 ready_in |-> breaker_ready; endproperty
	a_ready: assert property (p_ready) else $error("ready not reported");
	property p_clblk; st_ff.fsm == sgpc_pkg::SGPC_IDLE && cl_blk
		|=> st_ff.fsm != sgpc_pkg::SGPC_CLOSING && st_ff.fsm != sgpc_pkg::SGPC_SYNC; endproperty
	a_clblk: assert property (p_clblk) else $error("close not interlocked");
	property p_opblk; st_ff.fsm == sgpc_pkg::SGPC_IDLE && op_blk
		|=> st_ff.fsm != sgpc_pkg::SGPC_OPENING; endproperty
	a_opblk: assert property (p_opblk) else $error("open not interlocked");
	property p_nomanual; !st_ff.cfg.controlled ##1 !st_ff.cfg.controlled
		|-> st_ff.fsm == sgpc_pkg::SGPC_IDLE; endproperty
	a_nomanual: assert property (p_nomanual) else $error("manual on uncontrolled");
	property p_cfgrej; st_ff.cfg.switch_one && !st_ff.cfg.break_cap
		|=> st_ff.cfg_rej ##1 !open_relay || st_ff.rel_op[0] || st_ff.rel_op[1]; endproperty
	a_cfgrej: assert property (p_cfgrej) else $error("bad config taken");
	property p_trip; trip_src |=> st_ff.trip_act ##1 open_relay || !st_ff.rel_op[2]; endproperty
	a_trip: assert property (p_trip) else $error("trip not issued");
	property p_hold; $rose(st_ff.trip_act) && st_ff.hold >= 32'h3
		|-> st_ff.trip_act [*3]; endproperty
	a_hold: assert property (p_hold) else $error("trip hold too short");
	property p_latch; st_ff.trip_act && st_ff.cfg.latched && !ack && $stable(st_ff.cfg)
		|=> st_ff.trip_act; endproperty
	a_latch: assert property (p_latch) else $error("latched trip dropped");
	property p_move; st_ff.fsm == sgpc_pkg::SGPC_CLOSING && st_ff.cnt == 32'h0 && man_ok
		&& !st_ff.trip_act && position != `SGPC_POS_CLOSED |=> st_ff.sticky.close_fault; endproperty
	a_move: assert property (p_move) else $error("close move fault missed");
endmodule : sgpc_top
`default_nettype wire

// ### verif/sgpc_brk_model.sv
// Purpose: breaker model driving the auxiliary contacts from the relays
// Assumes: relays are levels; open wins if both are high
// Notes: contacts read neither position while the breaker travels
`timescale 1ns/1ps
`default_nettype none
module sgpc_brk_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// relay drive
	input wire logic close_relay,
	input wire logic open_relay,
	// bench override: stuck or odd contacts
	input wire logic ovr_en,
	input wire logic [1:0] ovr_val,
	// auxiliary contacts
	output logic aux_closed,
	output logic aux_open
);
	localparam int MOVE = 3;
	logic closed_ff;
	int cnt_ff;
	logic want_move;
	// frozen while overridden so a stuck test leaves no hidden travel
	assign want_move = !ovr_en && (closed_ff ? open_relay : (close_relay && !open_relay));
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !want_move)
			cnt_ff <= 0;
		else if (cnt_ff == MOVE)
			cnt_ff <= 0;
		else
			cnt_ff <= cnt_ff + 1;
		if (!aresetn)
			closed_ff <= 1'b0;
		else if (want_move && cnt_ff == MOVE)
			closed_ff <= !closed_ff;
	end
	assign aux_closed = ovr_en ? ovr_val[1] : (closed_ff && cnt_ff == 0);
	assign aux_open = ovr_en ? ovr_val[0] : (!closed_ff && cnt_ff == 0);
endmodule : sgpc_brk_model
`default_nettype wire

// ### verif/testbench.sv
// Purpose: self-checking bench for sgpc_top with a breaker model
// Assumes: bus answers are awaited, never counted; times in aclk cycles
// Notes: bready and rready stay high, which the bus allows
`include "sgpc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic aclk = 1'b0, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, trip_source_input;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, position, ovr_val, last_resp;
	logic aux_closed, aux_open, ready_in, removed_in, trip_latch_clear, sync_ok, ovr_en;
	logic external_close_request, external_open_request, close_relay, open_relay;
	logic breaker_ready, breaker_removed, earthed;
	logic [2:0] close_block_input, open_block_input;
	int errors = 0, check_count = 0, i, n;
	always #2.5 aclk = !aclk;
	sgpc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .aux_closed, .aux_open,
		.ready_in, .removed_in, .close_block_input, .open_block_input, .trip_source_input,
		.trip_latch_clear, .external_close_request, .external_open_request, .sync_ok,
		.position, .breaker_ready, .breaker_removed, .earthed, .close_relay, .open_relay);
	sgpc_brk_model brk (.aclk, .aresetn, .close_relay, .open_relay, .ovr_en, .ovr_val,
		.aux_closed, .aux_open);
	// ****************************************
	// tasks
	// ****************************************
	task summarize;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		last_resp = s_axi_bresp;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		last_resp = s_axi_rresp;
	endtask : rd
	function automatic logic [1:0] cur(input int sel);
		case (sel)
			0: return {1'b0, close_relay};
			1: return {1'b0, open_relay};
			default: return position;
		endcase
	endfunction : cur
	// waits a bounded time, then compares whatever is there
	task wait_for(input int sel, input logic [1:0] v);
		@(negedge aclk);
		for (int k = 0; k < 60 && cur(sel) !== v; k++)
			@(negedge aclk);
		check(32'(cur(sel)), 32'(v));
		// back onto the rising edge so the next stimulus lands there
		@(posedge aclk);
	endtask : wait_for
	task trip;
		@(posedge aclk);
		trip_source_input <= 8'h01 << ($urandom % 8);
		@(posedge aclk);
		trip_source_input <= 8'h00;
	endtask : trip
	function automatic logic [1:0] exp_pos(input logic c, input logic o);
		return c ? (o ? `SGPC_POS_DISTURB : `SGPC_POS_CLOSED) : (o ? `SGPC_POS_OPEN : `SGPC_POS_INDET);
	endfunction : exp_pos
	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ready_in, removed_in} = 5'h00;
		{trip_latch_clear, sync_ok, external_close_request, external_open_request} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, trip_source_input} = 24'h000000;
		{close_block_input, open_block_input} = 6'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		{s_axi_bready, s_axi_rready, ovr_en} = 3'h7;
		ovr_val = 2'h0;
		void'($urandom(18397));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`SGPC_OFS_CFG); check(d, 32'h00000081);
		rd(`SGPC_OFS_RELAY); check(d, 32'h00000601);
		rd(8'h24); check(32'(last_resp), 32'(`SGPC_RESP_SLVERR));
		wr(8'h22, 32'hFFFFFFFF); check(32'(last_resp), 32'(`SGPC_RESP_SLVERR));
		for (i = 0; i < 16; i++)
		begin
			@(posedge aclk);
			{ovr_val, ready_in, removed_in} <= (i < 4) ? 4'(i * 4) : 4'($urandom);
			repeat (2) @(negedge aclk);
			check(32'(position), 32'(exp_pos(ovr_val[1], ovr_val[0])));
			check(32'(breaker_ready), 32'(ready_in));
			check(32'(breaker_removed), 32'(removed_in));
		end
		rd(`SGPC_OFS_STAT); check(32'(d[1:0]), 32'(exp_pos(ovr_val[1], ovr_val[0])));
		wr(`SGPC_OFS_CFG, 32'h85); check(32'(last_resp), 32'(`SGPC_RESP_OKAY));
		ovr_val <= 2'b10;
		repeat (3) @(negedge aclk);
		check(32'(earthed), 32'h1);
		wr(`SGPC_OFS_CFG, 32'h83);
		ovr_en <= 1'b0;
		wr(`SGPC_OFS_CMD, 32'h1 << `SGPC_CMD_CLOSE);
		wait_for(0, 2'h1);
		wait_for(2, `SGPC_POS_CLOSED);
		open_block_input <= 3'b001 << ($urandom % 3);
		wr(`SGPC_OFS_CMD, 32'h1 << `SGPC_CMD_OPEN);
		repeat (4) @(negedge aclk);
		check(32'(open_relay), 32'h0);
		rd(`SGPC_OFS_STAT); check(32'(d[10]), 32'h1);
		open_block_input <= 3'b000;
		external_open_request <= 1'b1;
		wait_for(2, `SGPC_POS_OPEN);
		external_open_request <= 1'b0;
		close_block_input <= 3'b001 << ($urandom % 3);
		wr(`SGPC_OFS_CMD, 32'h1 << `SGPC_CMD_CLOSE);
		rd(`SGPC_OFS_STAT); check(32'(d[9]), 32'h1);
		close_block_input <= 3'b000;
		// contacts stuck open: the close timer must expire
		wr(`SGPC_OFS_MVON, 32'h5);
		ovr_en <= 1'b1;
		ovr_val <= 2'b01;
		wr(`SGPC_OFS_CMD, 32'h1 << `SGPC_CMD_CLOSE);
		wait_for(0, 2'h0);
		rd(`SGPC_OFS_STAT); check(32'(d[11]), 32'h1);
		ovr_en <= 1'b0;
		wr(`SGPC_OFS_CFG, 32'h81);
		wr(`SGPC_OFS_HOLD, 32'h5);
		wr(`SGPC_OFS_CMD, 32'h1 << `SGPC_CMD_CLOSE);
		repeat (4) @(negedge aclk);
		check(32'(close_relay), 32'h0);
		trip;
		wait_for(1, 2'h1);
		for (n = 0; n < 100 && open_relay === 1'b1; n++)
			@(negedge aclk);
		check(32'(n >= 5 && n <= 10), 32'h1);
		wr(`SGPC_OFS_CFG, 32'h89);
		trip;
		repeat (30) @(negedge aclk);
		check(32'(open_relay), 32'h1);
		wr(`SGPC_OFS_CMD, 32'h1 << `SGPC_CMD_ACK);
		wait_for(1, 2'h0);
		wr(`SGPC_OFS_CFG, 32'h99);
		trip;
		repeat (20) @(posedge aclk);
		trip_latch_clear <= 1'b1;
		wait_for(1, 2'h0);
		trip_latch_clear <= 1'b0;
		wr(`SGPC_OFS_CFG, 32'h82);
		trip;
		wr(`SGPC_OFS_CMD, 32'h1 << `SGPC_CMD_CLOSE);
		repeat (4) @(negedge aclk);
		check(32'({close_relay, open_relay}), 32'h0);
		rd(`SGPC_OFS_STAT); check(32'(d[8]), 32'h1);
		wr(`SGPC_OFS_CFG, 32'h00);
		trip;
		wr(`SGPC_OFS_CMD, 32'h1 << `SGPC_CMD_CLOSE);
		repeat (4) @(negedge aclk);
		check(32'({close_relay, open_relay}), 32'h0);
		// synchronous close: abort after the wait limit, then a good one
		wr(`SGPC_OFS_SYNC, 32'h5);
		wr(`SGPC_OFS_CFG, 32'hE3);
		wr(`SGPC_OFS_CMD, 32'h1 << `SGPC_CMD_CLOSE);
		repeat (12) @(negedge aclk);
		check(32'(close_relay), 32'h0);
		rd(`SGPC_OFS_STAT); check(32'(d[13]), 32'h1);
		sync_ok <= 1'b1;
		wr(`SGPC_OFS_CMD, 32'h1 << `SGPC_CMD_CLOSE);
		wait_for(2, `SGPC_POS_CLOSED);
		summarize();
	end
	initial
	begin
		#200000;
		errors++;
		summarize();
	end
endmodule : testbench
`default_nettype wire
